/* File: ee2w_slave.sv */
// two-wire slave port of a 32-kbit serial eeprom with 64-byte write cache
`timescale 1ns/10ps
//
// Operation
// - falling sda while scl high is a start, honoured in any state
// - rising sda while scl high is a stop, ends the current transfer
// - sda sampled on scl rise, driven only after scl fall, one bit per pulse
// - start detection armed on the first clock after reset, as the synchroniser resets both lines high
// - ninth pulse: receiver holds sda low through high phase to acknowledge
// - no acknowledge at all while the internal write cycle runs
// - master nack after read byte: sda released so master can stop
// - first byte after start: type code, three select bits, read/write bit
// - control byte acknowledged only on type code and strap match
// - two address bytes, high first, twelve bits used, top four ignored
// - byte write: control, addresses and data acknowledged, stop starts write
// - page write: data kept in 64-byte cache, committed only after stop
// - each data byte steps low six pointer bits, upper bits held
// - cache overflow wraps to line zero byte zero, overwriting data
// - stop at any byte boundary launches write with captured data
// - polling: control byte nacked while busy, acknowledged once done
// - pointer holds last read location plus one; after a write, start address plus byte count within its 64-byte block
// - address then repeated start loads pointer without programming
// - master ack fetches next byte, pointer steps after each byte
// - write time is a fixed slot for every page loaded, even partial
// - first write byte lands in line zero at address low three bits
// - only bytes actually loaded are programmed into the array
//
module ee2w_slave
	import ee2w_pkg::*;
#(
	parameter int unsigned PAGE_CYCLES = EE_PAGE_CYCLES,
	parameter logic [3:0]  DEVICE_TYPE = 4'h6 // arbitrary value
) (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       resetn_i,
	// two-wire bus
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_n_o,
	// device select straps
	input  wire logic [2:0] device_select_straps_i,
	// status
	output logic            busy_o,
	output logic            selected_o
);

	if (PAGE_CYCLES < 1) begin : g_chk
		$error("page cycle count must be at least one");
	end

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisation and bus conditions

	logic [EE_PINS_W-1:0] pins_q;
	ee2w_pins_s           pins;
	logic                 scl_q;
	logic                 sda_q;
	logic                 bus_ok;

	ee2w_sync #(
		.W       (EE_PINS_W),
		.RST_VAL (EE_PINS_IDLE)
	) u_sync (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.d_i      ({scl_i, sda_i, device_select_straps_i}),
		.q_o      (pins_q)
	);

	assign pins = ee2w_pins_s'(pins_q);

	// previous levels for edge finding, read only after the synchroniser
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= pins.scl;
			sda_q <= pins.sda;
		end
	end

	// start enable, set on the first clock after reset from the synchroniser's all-high reset value
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			bus_ok <= 1'b0;
		end else if (pins.scl && pins.sda) begin
			bus_ok <= 1'b1;
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	// line events, starts take priority over everything
	assign scl_rise  = pins.scl & ~scl_q;
	assign scl_fall  = ~pins.scl & scl_q;
	assign start_det = bus_ok & scl_q & pins.scl & sda_q & ~pins.sda;
	assign stop_det  = scl_q & pins.scl & ~sda_q & pins.sda;

	////////////////////////////////////////////////////////////////////////////
	// storage

	logic [7:0]               mem [EE_MEM_BYTES];
	logic [7:0]               cache [EE_CACHE_BYTES];
	logic [EE_CACHE_BYTES-1:0] loaded;
	logic [EE_CIDX_W-1:0]     cidx;
	logic [EE_PAGE_W-1:0]     base_page;
	logic                     wr_pend;

	////////////////////////////////////////////////////////////////////////////
	// sequencer state

	ee2w_state_e          state;
	ee2w_kind_e           kind;
	logic [3:0]           bitcnt;
	logic [7:0]           shreg;
	logic                 rd_mode;
	logic [EE_ADDR_W-1:0] ptr;
	logic [3:0]           addr_hi;
	logic                 busy_now;
	logic                 tmr_busy;
	logic                 cmt_run;

	logic                 ev_ok;
	logic                 byte_done;
	logic                 ack_ok;
	logic                 ctrl_match;
	logic                 rd_load;
	logic [7:0]           rd_byte;

	// bit events count only when no start or stop wins the cycle
	assign ev_ok     = ~start_det & ~stop_det;
	assign byte_done = ev_ok & (state == ST_RX) & scl_fall & (bitcnt == EE_BYTE_BITS);
	assign busy_now  = cmt_run | tmr_busy;

	// control byte decode against the fixed type and the straps
	assign ctrl_match = (shreg[EE_TYPE_HI:EE_TYPE_LO] == DEVICE_TYPE)
		& (shreg[EE_SEL_HI:EE_SEL_LO] == pins.sel);

	// acknowledge decision at the end of each received byte
	always_comb begin
		if (kind == BK_CTRL) begin
			ack_ok = ctrl_match & ~busy_now;
		end else begin
			ack_ok = 1'b1;
		end
	end

	// a read byte is fetched when the ack slot ends in read mode
	assign rd_load = ev_ok & scl_fall
		& (((state == ST_RXACK) & rd_mode) | (state == ST_TXACK));
	assign rd_byte = mem[ptr];

	////////////////////////////////////////////////////////////////////////////
	// bit level sequencer

	// sda output enable doubles as the transmitted bit: 1 releases the line
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			state      <= ST_IDLE;
			bitcnt     <= 4'h0;
			shreg      <= 8'h00;
			sda_oe_n_o <= 1'b1;
		end else if (start_det) begin
			state      <= ST_RX;
			bitcnt     <= 4'h0;
			sda_oe_n_o <= 1'b1;
		end else if (stop_det) begin
			state      <= ST_IDLE;
			sda_oe_n_o <= 1'b1;
		end else begin
			case (state)
				ST_RX: begin
					if (scl_rise && bitcnt != EE_BYTE_BITS) begin
						shreg  <= {shreg[6:0], pins.sda};
						bitcnt <= bitcnt + 4'h1;
					end else if (byte_done) begin
						bitcnt <= 4'h0;
						if (ack_ok) begin
							state      <= ST_RXACK;
							sda_oe_n_o <= 1'b0;
						end else begin
							state <= ST_IGNORE;
						end
					end
				end
				ST_RXACK: begin
					// ack is held until scl falls again, then next phase
					if (scl_fall) begin
						if (rd_mode) begin
							state      <= ST_TX;
							shreg      <= rd_byte;
							sda_oe_n_o <= rd_byte[7];
							bitcnt     <= 4'h1;
						end else begin
							state      <= ST_RX;
							sda_oe_n_o <= 1'b1;
						end
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (bitcnt == EE_BYTE_BITS) begin
							state      <= ST_TXACK;
							sda_oe_n_o <= 1'b1;
							bitcnt     <= 4'h0;
						end else begin
							shreg      <= {shreg[6:0], 1'b0};
							sda_oe_n_o <= shreg[6];
							bitcnt     <= bitcnt + 4'h1;
						end
					end
				end
				ST_TXACK: begin
					if (scl_rise && pins.sda) begin
						state <= ST_IGNORE;
					end else if (scl_fall) begin
						state      <= ST_TX;
						shreg      <= rd_byte;
						sda_oe_n_o <= rd_byte[7];
						bitcnt     <= 4'h1;
					end
				end
				ST_IGNORE: begin
					sda_oe_n_o <= 1'b1;
				end
				default: begin
					sda_oe_n_o <= 1'b1;
				end
			endcase
		end
	end

	// sda is open drain: the driven level is always low
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			sda_o <= 1'b0;
		end else begin
			sda_o <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// byte meaning

	// which byte comes next, and whether the transfer is a read
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			kind    <= BK_CTRL;
			rd_mode <= 1'b0;
		end else if (start_det) begin
			kind    <= BK_CTRL;
			rd_mode <= 1'b0;
		end else if (byte_done && ack_ok) begin
			case (kind)
				BK_CTRL: begin
					rd_mode <= shreg[EE_RW_BIT];
					kind    <= shreg[EE_RW_BIT] ? BK_CTRL : BK_ADDRH;
				end
				BK_ADDRH: kind <= BK_ADDRL;
				BK_ADDRL: kind <= BK_DATA;
				BK_DATA:  kind <= BK_DATA;
				default:  kind <= BK_CTRL;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// address pointer

	// pointer survives between transfers for current address reads
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			ptr     <= '0;
			addr_hi <= 4'h0;
		end else if (byte_done && ack_ok && kind == BK_ADDRH) begin
			addr_hi <= shreg[EE_AHI_HI:0];
		end else if (byte_done && ack_ok && kind == BK_ADDRL) begin
			ptr <= {addr_hi, shreg};
		end else if (byte_done && ack_ok && kind == BK_DATA) begin
			ptr[EE_CIDX_W-1:0] <= ptr[EE_CIDX_W-1:0] + 6'h01;
		end else if (rd_load) begin
			ptr <= ptr + 12'h001;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// write cache

	// the cache line of a byte is always counted from line zero
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			cidx      <= '0;
			loaded    <= '0;
			base_page <= '0;
			wr_pend   <= 1'b0;
		end else if (start_det) begin
			wr_pend <= 1'b0;
		end else if (stop_det && wr_pend) begin
			wr_pend <= 1'b0;
		end else if (byte_done && ack_ok && kind == BK_ADDRL) begin
			cidx      <= {3'h0, shreg[EE_OFS_W-1:0]};
			loaded    <= '0;
			base_page <= {addr_hi, shreg[7:EE_OFS_W]};
		end else if (byte_done && ack_ok && kind == BK_DATA) begin
			loaded[cidx] <= 1'b1;
			cidx         <= cidx + 6'h01;
			wr_pend      <= 1'b1;
		end
	end

	// cache data, no reset since only loaded bytes are ever used
	always_ff @(posedge clk_i) begin
		if (byte_done && ack_ok && kind == BK_DATA && !start_det) begin
			cache[cidx] <= shreg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// commit to the array

	logic                 cmt_go;
	logic [EE_CIDX_W-1:0] cmt_idx;
	logic [EE_PAGE_W-1:0] cmt_page;
	logic [3:0]           page_cnt;
	logic [EE_LINES-1:0]  line_used;

	assign cmt_go   = stop_det & wr_pend;
	assign cmt_page = base_page + EE_PAGE_W'(cmt_idx[EE_CIDX_W-1:EE_OFS_W]);

	// a line counts as a page as soon as one byte of it was loaded
	for (genvar l = 0; l < EE_LINES; l++) begin : g_line
		assign line_used[l] = |loaded[l*EE_LINE_BYTES +: EE_LINE_BYTES];
	end

	// number of pages that need a write slot
	always_comb begin
		page_cnt = 4'h0;
		for (int l = 0; l < EE_LINES; l++) begin
			if (line_used[l]) begin
				page_cnt = page_cnt + 4'h1;
			end
		end
	end

	// one cache byte per clock; far shorter than the page slot
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			cmt_run <= 1'b0;
			cmt_idx <= '0;
		end else if (cmt_go) begin
			cmt_run <= 1'b1;
			cmt_idx <= '0;
		end else if (cmt_run) begin
			cmt_idx <= cmt_idx + 6'h01;
			if (cmt_idx == EE_CIDX_W'(EE_CACHE_BYTES - 1)) begin
				cmt_run <= 1'b0;
			end
		end
	end

	// array write, skipping bytes that never arrived
	always_ff @(posedge clk_i) begin
		if (cmt_run && loaded[cmt_idx]) begin
			mem[{cmt_page, cmt_idx[EE_OFS_W-1:0]}] <= cache[cmt_idx];
		end
	end

	// busy time scales with the loaded pages
	ee2w_wrtimer #(
		.PAGE_CYCLES (PAGE_CYCLES)
	) u_timer (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.start_i  (cmt_go),
		.pages_i  (page_cnt),
		.busy_o   (tmr_busy)
	);

	////////////////////////////////////////////////////////////////////////////
	// status outputs

	// busy is reported from the stop that launches the write
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			busy_o <= 1'b0;
		end else begin
			busy_o <= busy_now | cmt_go;
		end
	end

	// addressed: past an acknowledged control byte and not dropped out
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			selected_o <= 1'b0;
		end else if (start_det || stop_det) begin
			selected_o <= 1'b0;
		end else if (byte_done && kind == BK_CTRL) begin
			selected_o <= ack_ok;
		end else if (state == ST_IGNORE) begin
			selected_o <= 1'b0;
		end
	end

endmodule : ee2w_slave

/* File: ee2w_pkg.sv */
// shared constants and types of the two-wire eeprom slave port
package ee2w_pkg;

	// array and cache geometry
	localparam int unsigned EE_ADDR_W      = 12;
	localparam int unsigned EE_MEM_BYTES   = 4096;
	localparam int unsigned EE_CACHE_BYTES = 64;
	localparam int unsigned EE_LINES       = 8;
	localparam int unsigned EE_LINE_BYTES  = 8;
	localparam int unsigned EE_CIDX_W      = 6;
	localparam int unsigned EE_OFS_W       = 3;
	localparam int unsigned EE_PAGE_W      = 9;

	// control byte and address byte fields
	localparam int unsigned EE_TYPE_HI = 7;
	localparam int unsigned EE_TYPE_LO = 4;
	localparam int unsigned EE_SEL_HI  = 3;
	localparam int unsigned EE_SEL_LO  = 1;
	localparam int unsigned EE_RW_BIT  = 0;
	localparam int unsigned EE_AHI_HI  = 3;
	localparam logic [3:0]  EE_BYTE_BITS = 4'h8;

	// write cycle time per cache page
	localparam int unsigned EE_CLK_PERIOD_NS = 5;
	localparam int unsigned EE_TWR_NS        = 5000000;
	localparam int unsigned EE_PAGE_CYCLES   = EE_TWR_NS / EE_CLK_PERIOD_NS;

	// bus sequencer states, gray along the usual path
	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_RX     = 3'h1,
		ST_RXACK  = 3'h3,
		ST_TX     = 3'h2,
		ST_TXACK  = 3'h6,
		ST_IGNORE = 3'h4
	} ee2w_state_e;

	// meaning of the next received byte
	typedef enum logic [1:0] {
		BK_CTRL  = 2'h0,
		BK_ADDRH = 2'h1,
		BK_ADDRL = 2'h3,
		BK_DATA  = 2'h2
	} ee2w_kind_e;

	// synchronised pin levels
	typedef struct packed {
		logic       scl;
		logic       sda;
		logic [2:0] sel;
	} ee2w_pins_s;

	localparam int unsigned EE_PINS_W    = 5;
	localparam logic [4:0]  EE_PINS_IDLE = 5'h1f;

endpackage : ee2w_pkg

/* File: ee2w_sync.sv */
// two flip-flop synchroniser for a group of pin levels
`timescale 1ns/10ps
module ee2w_sync #(
	parameter int unsigned W         = 1,
	parameter logic [W-1:0] RST_VAL  = '0
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         resetn_i,
	// levels
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	// one pair of flops per bit; the first one feeds only the second
	for (genvar b = 0; b < W; b++) begin : g_bit
		logic meta;
		always_ff @(posedge clk_i) begin
			if (!resetn_i) begin
				meta   <= RST_VAL[b];
				q_o[b] <= RST_VAL[b];
			end else begin
				meta   <= d_i[b];
				q_o[b] <= meta;
			end
		end
	end
endmodule : ee2w_sync

/* File: ee2w_wrtimer.sv */
// self-timed write cycle timer, one fixed slot per loaded page
`timescale 1ns/10ps
module ee2w_wrtimer #(
	parameter int unsigned PAGE_CYCLES = 1000
) (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       resetn_i,
	// launch
	input  wire logic       start_i,
	input  wire logic [3:0] pages_i,
	// state
	output logic            busy_o
);
	localparam int unsigned CW = $clog2(PAGE_CYCLES + 1);

	if (PAGE_CYCLES < 1) begin : g_chk
		$error("page cycle count must be at least one");
	end

	logic [CW-1:0] cyc;
	logic [3:0]    left;

	// count each page slot down, then the pages
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			busy_o <= 1'b0;
			cyc    <= '0;
			left   <= 4'h0;
		end else if (start_i) begin
			busy_o <= (pages_i != 4'h0);
			cyc    <= CW'(PAGE_CYCLES - 1);
			left   <= pages_i;
		end else if (busy_o) begin
			if (cyc != '0) begin
				cyc <= cyc - CW'(1);
			end else if (left <= 4'h1) begin
				busy_o <= 1'b0;
			end else begin
				left <= left - 4'h1;
				cyc  <= CW'(PAGE_CYCLES - 1);
			end
		end
	end
endmodule : ee2w_wrtimer

/* File: ee2w_slave_asserts.sv */
// concurrent checks on the ports of the two-wire eeprom slave port
`timescale 1ns/10ps
module ee2w_slave_asserts #(
	parameter int unsigned PAGE_CYCLES = 50
) (
	// clock and reset
	input wire logic       clk_i,
	input wire logic       resetn_i,
	// two-wire bus
	input wire logic       scl_i,
	input wire logic       sda_i,
	input wire logic       sda_o,
	input wire logic       sda_oe_n_o,
	// straps and status
	input wire logic [2:0] device_select_straps_i,
	input wire logic       busy_o,
	input wire logic       selected_o
);
	int unsigned busy_cnt;

	////////////////////////////////////////////////////////////////////////////////
	// length of the current write cycle, cleared while idle
	always_ff @(posedge clk_i) begin
		if (!resetn_i || !busy_o) begin
			busy_cnt <= 0;
		end else begin
			busy_cnt <= busy_cnt + 1;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	////////////////////////////////////////////////////////////////////////////////
	// pin behaviour
	AST_OPEN_DRAIN: assert property (sda_o == 1'b0)
		else $error("sda driven high");
	AST_NO_ACK_BUSY: assert property (busy_o |-> sda_oe_n_o)
		else $error("sda pulled during write cycle");
	AST_CHANGE_SCL_LOW: assert property ($changed(sda_oe_n_o) |-> !scl_i)
		else $error("sda drive changed while scl high");
	AST_PULL_HOLDS: assert property ($fell(sda_oe_n_o) |-> (!sda_oe_n_o) [*8])
		else $error("low drive shorter than a bit");
	// selection and write cycle
	AST_SELECT_NOT_BUSY: assert property ($rose(selected_o) |-> !busy_o)
		else $error("selected during write cycle");
	AST_STOP_DESELECTS: assert property (
		($rose(sda_i) && scl_i && $past(scl_i)) |-> ##[1:6] !selected_o)
		else $error("still selected after stop");
	AST_BUSY_AFTER_STOP: assert property ($rose(busy_o) |-> scl_i && sda_i)
		else $error("write cycle began without stop");
	AST_BUSY_MIN: assert property ($fell(busy_o) |-> busy_cnt >= PAGE_CYCLES)
		else $error("write cycle too short");
	AST_BUSY_MAX: assert property ($fell(busy_o) |-> busy_cnt <= 8 * PAGE_CYCLES + 72)
		else $error("write cycle too long");

	// main scenarios reached
	cover property ($rose(selected_o));
	cover property ($rose(busy_o));
	cover property ($fell(busy_o));
endmodule : ee2w_slave_asserts

bind ee2w_slave ee2w_slave_asserts #(.PAGE_CYCLES(PAGE_CYCLES)) u_chk (
	.clk_i                 (clk_i),
	.resetn_i              (resetn_i),
	.scl_i                 (scl_i),
	.sda_i                 (sda_i),
	.sda_o                 (sda_o),
	.sda_oe_n_o            (sda_oe_n_o),
	.device_select_straps_i(device_select_straps_i),
	.busy_o                (busy_o),
	.selected_o            (selected_o)
);

/* File: ee2w_master_model.sv */
// behavioural two-wire bus master, 48 ns bit period
`timescale 1ns/10ps
module ee2w_master_model (
	// bus drive, 1 releases the line
	output logic      scl_o,
	output logic      sda_o,
	// resolved data wire
	input  wire logic sda_i
);
	// bus idle: clock stands high outside frames
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// one bit: data moves only in the low phase, sampled mid high
	// non-blocking so a pin edge that lands on a clock edge never races the synchroniser
	task bit_io(input logic b, output logic r);
		#6 sda_o <= b;
		#18 scl_o <= 1'b1;
		#12 r = sda_i;
		#12 scl_o <= 1'b0;
	endtask : bit_io

	// start, also usable as repeated start after an acknowledge
	task start();
		#6 sda_o <= 1'b1;
		#18 scl_o <= 1'b1;
		#24 sda_o <= 1'b0;
		#24 scl_o <= 1'b0;
	endtask : start

	// stop leaves both lines high for the bus free time
	task stop();
		#6 sda_o <= 1'b0;
		#18 scl_o <= 1'b1;
		#24 sda_o <= 1'b1;
		#24;
	endtask : stop

	// eight bits msb first, ninth pulse carries nb out and the answer back
	task xfer(input logic [7:0] d, input logic nb, output logic [7:0] q, output logic a);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], q[i]);
		end
		bit_io(nb, a);
	endtask : xfer
endmodule : ee2w_master_model

/* File: ee2w_slave_test.sv */
// self-checking bench of the two-wire eeprom slave port
`timescale 1ns/10ps
module ee2w_slave_test;
	localparam int unsigned PC    = 100; // wide margin for the busy poll
	localparam logic [2:0]  STRAP = 3'h5;
	localparam logic [7:0]  CW    = {4'h6, STRAP, 1'b0};
	localparam logic [7:0]  CR    = {4'h6, STRAP, 1'b1};

	logic       clk_i;
	logic       resetn_i;
	logic [2:0] straps;
	logic       scl;
	logic       sda_m;
	logic       sda_w;
	logic       sda_d;
	logic       sda_oe_n;
	logic       busy;
	logic       selected;
	int         err_count = 0;
	int         tests_run = 0;
	int         cycles = 0;

	////////////////////////////////////////////////////////////////////////////////
	// clock, wire resolution with pull-up, design and master
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	assign sda_w = sda_m & (sda_oe_n | sda_d);

	ee2w_slave #(.PAGE_CYCLES(PC)) u_dut (
		.clk_i                 (clk_i),
		.resetn_i              (resetn_i),
		.scl_i                 (scl),
		.sda_i                 (sda_w),
		.sda_o                 (sda_d),
		.sda_oe_n_o            (sda_oe_n),
		.device_select_straps_i(straps),
		.busy_o                (busy),
		.selected_o            (selected)
	);
	ee2w_master_model u_m (.scl_o(scl), .sda_o(sda_m), .sda_i(sda_w));

	////////////////////////////////////////////////////////////////////////////////
	// compare, report and finish
	task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task summarize();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : summarize

	// byte to the device, ack expected or not
	task send(input logic [7:0] d, input logic ack);
		logic [7:0] q;
		logic       a;
		u_m.xfer(d, 1'b1, q, a);
		chk("ack", {7'h0, !ack}, {7'h0, a});
	endtask : send

	// byte from the device, last one left without acknowledge
	task rd(input logic [7:0] exp, input logic last);
		logic [7:0] q;
		logic       a;
		u_m.xfer(8'hff, last, q, a);
		chk("data", exp, q);
	endtask : rd

	// bounded wait for the write cycle to finish
	task wait_done();
		int n;
		n = 0;
		// sample on the falling edge, away from the edge that updates busy
		while (busy !== 1'b0 && n < 4000) begin
			@(negedge clk_i);
			n++;
		end
		chk("busy_end", 8'h00, {7'h0, busy});
	endtask : wait_done

	// hang guard, the whole run is about 10500 cycles
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 40000) begin
			err_count++;
			summarize();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		resetn_i <= 1'b0;
		straps   <= STRAP;
		repeat (6) @(posedge clk_i);
		resetn_i <= 1'b1;
		repeat (10) @(posedge clk_i);
		chk("oe_reset", 8'h01, {7'h0, sda_oe_n});
		// wrong select bits, then wrong type code: ignored until stop
		u_m.start();
		send({4'h6, 3'h2, 1'b0}, 1'b0);
		chk("selected", 8'h00, {7'h0, selected});
		u_m.stop();
		u_m.start();
		send({4'h9, STRAP, 1'b0}, 1'b0);
		u_m.stop();
		// three bytes at 0x0fe cross into cache line 1
		u_m.start();
		send(CW, 1'b1);
		chk("selected", 8'h01, {7'h0, selected});
		send(8'h00, 1'b1);
		send(8'hfe, 1'b1);
		for (int k = 0; k < 3; k++) send(8'ha0 + 8'(k), 1'b1);
		u_m.stop();
		chk("busy", 8'h01, {7'h0, busy});
		// polling: refused while busy, accepted after
		u_m.start();
		send(CW, 1'b0);
		u_m.stop();
		wait_done();
		u_m.start();
		send(CW, 1'b1);
		u_m.stop();
		// random read of two, then current address read
		u_m.start();
		send(CW, 1'b1);
		send(8'h00, 1'b1);
		send(8'hfe, 1'b1);
		u_m.start();
		send(CR, 1'b1);
		rd(8'ha0, 1'b0);
		rd(8'ha1, 1'b1);
		u_m.stop();
		u_m.start();
		send(CR, 1'b1);
		rd(8'ha2, 1'b1);
		u_m.stop();
		// 65 bytes at 0x200: the last overwrites cache byte zero
		u_m.start();
		send(CW, 1'b1);
		send(8'h02, 1'b1);
		send(8'h00, 1'b1);
		for (int k = 0; k < 65; k++) send(8'h40 + 8'(k), 1'b1);
		u_m.stop();
		wait_done();
		u_m.start();
		send(CR, 1'b1);
		rd(8'h41, 1'b1);
		u_m.stop();
		u_m.start();
		send(CW, 1'b1);
		send(8'h02, 1'b1);
		send(8'h00, 1'b1);
		u_m.start();
		send(CR, 1'b1);
		rd(8'h80, 1'b0);
		rd(8'h41, 1'b0);
		rd(8'h42, 1'b1);
		u_m.stop();
		// one byte into a filled page: its neighbours keep their data
		u_m.start();
		send(CW, 1'b1);
		send(8'h02, 1'b1);
		send(8'h3e, 1'b1);
		send(8'h5a, 1'b1);
		u_m.stop();
		wait_done();
		u_m.start();
		send(CW, 1'b1);
		send(8'h02, 1'b1);
		send(8'h3d, 1'b1);
		u_m.start();
		send(CR, 1'b1);
		rd(8'h7d, 1'b0);
		rd(8'h5a, 1'b0);
		rd(8'h7f, 1'b1);
		u_m.stop();
		chk("oe_end", 8'h01, {7'h0, sda_oe_n});
		summarize();
	end
endmodule : ee2w_slave_test
